// File: logic/gpm_defines.vh
// Register offsets, field values and bus widths for the GPIO port block
`ifndef GPM_DEFINES_VH
`define GPM_DEFINES_VH

// APB address and data widths
`define GPM_ADDR_W 12
`define GPM_DATA_W 32
`define GPM_STRB_W 4
`define GPM_BYTE_W 8

// Register byte offsets, one aligned word each
`define GPM_OFF_DIR 12'h000
`define GPM_OFF_VAL 12'h004
`define GPM_OFF_LAT 12'h008
`define GPM_OFF_ACFG 12'h00c
`define GPM_OFF_OWN 12'h010

// Field meanings
`define GPM_DIR_INPUT 1'b1
`define GPM_DIR_OUTPUT 1'b0
`define GPM_ACFG_DIGITAL 1'b1
`define GPM_ACFG_ANALOG 1'b0

// Reset values of single bits
`define GPM_LAT_RST 1'b0
`define GPM_ACFG_RST 1'b0
`define GPM_BIT_ZERO 1'b0
`define GPM_BIT_ONE 1'b1

// Synchroniser depth reset level
`define GPM_SYNC_RST 1'b0

`endif

// File: logic/gpm_sync.v
// Two-flop synchroniser for a vector of pin levels
`timescale 1ns/100ps
`default_nettype none
`include "gpm_defines.vh"

module gpm_sync #(
  parameter W = 16
) (
  input wire CLK,
  input wire SRST,
  input wire [W-1:0] D,
  output wire [W-1:0] Q
);

  reg [W-1:0] meta_reg;
  reg [W-1:0] sync_reg;

  // First stage feeds only the second stage; nothing else looks at it
  always @(posedge CLK) begin
    if (SRST) begin
      meta_reg <= {W{`GPM_SYNC_RST}};
      sync_reg <= {W{`GPM_SYNC_RST}};
    end else begin
      meta_reg <= D;
      sync_reg <= meta_reg;
    end
  end

  assign Q = sync_reg;

endmodule
`default_nettype wire

// File: logic/gpm_port.v
// GPIO port with direction, pin value, latch and peripheral output muxing
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "gpm_defines.vh"

module gpm_port #(
  parameter N = 16,
  parameter NP = 2,
  parameter [N-1:0] IMPL_MASK = {N{1'b1}},
  parameter [N-1:0] ANALOG_MASK = {N{1'b0}},
  parameter [NP-1:0] PER_TAKES_PIN = {{(NP-1){1'b0}}, 1'b1}
) (
  // Clock and reset
  input wire CLK,
  input wire SRST,
  // APB slave
  input wire PSEL,
  input wire PENABLE,
  input wire PWRITE,
  input wire [`GPM_ADDR_W-1:0] PADDR,
  input wire [`GPM_DATA_W-1:0] PWDATA,
  input wire [`GPM_STRB_W-1:0] PSTRB,
  output reg [`GPM_DATA_W-1:0] PRDATA,
  output reg PREADY,
  output reg PSLVERR,
  // Pad side
  input wire [N-1:0] PIN_I,
  output reg [N-1:0] PIN_O,
  output reg [N-1:0] PIN_OE,
  // Peripheral side, bit p*N+i is peripheral p on pin i
  input wire [NP*N-1:0] PER_EN,
  input wire [NP*N-1:0] PER_OUT,
  input wire [NP*N-1:0] PER_OE,
  output reg [N-1:0] PER_IN
);

  // Timing seen from outside the block:
  //   every APB access has one wait state; ready stands one cycle
  //   a register write reaches the pads one edge after it lands
  //   a pad change shows in a pin read three edges later
  //   peripheral inputs lag the pad by three edges
  // Ownership: only peripherals flagged in PER_TAKES_PIN can take a
  // pad; the lowest index among the enabled ones wins
  // Input-only functions never take the pad, so software can drive
  // them from the latch with the pin set as output
  // Limitation: a read-modify-write on the pin value register copies
  // the sampled input levels into the latch; the latch register is the
  // safe target for bit updates
  // Trade-off: the two-flop synchroniser costs latency on every pin read
  // but keeps a changing pad from reaching several flops unevenly

  reg [N-1:0] dir_reg;
  reg [N-1:0] lat_reg;
  reg [N-1:0] acfg_reg;
  reg [N-1:0] dir_next;
  reg [N-1:0] lat_next;
  reg [N-1:0] acfg_next;
  reg [N-1:0] pin_o_next;
  reg [N-1:0] pin_oe_next;
  reg [N-1:0] own_reg;
  reg [`GPM_DATA_W-1:0] rdata_next;
  reg dec_err;

  wire [N-1:0] pin_sync;
  wire [N-1:0] dig_mask;
  wire [N-1:0] pin_read;
  wire [N-1:0] owned;
  wire [N-1:0] per_o;
  wire [N-1:0] per_oe;
  wire [`GPM_DATA_W-1:0] wmask_full;
  wire [N-1:0] wmask;
  wire [N-1:0] wdata;
  wire acc_start;
  wire acc_done;
  wire wr_go;
  wire hit_dir;
  wire hit_val;
  wire hit_lat;
  wire hit_acfg;
  wire wr_dir;
  wire wr_lat;
  wire wr_acfg;
  wire [N-1:0] dir_merge;
  wire [N-1:0] lat_merge;
  wire [N-1:0] acfg_merge;

  // Pins are brought into the clock domain before any reader sees them
  gpm_sync #(
    .W(N)
  ) u_sync (
    .CLK(CLK),
    .SRST(SRST),
    .D(PIN_I),
    .Q(pin_sync)
  );

  // Digital only where implemented and, on converter pins, configured digital
  assign dig_mask = IMPL_MASK &
                    (~ANALOG_MASK | acfg_reg);

  // Pin read path stays live even when a peripheral owns the pin
  assign pin_read = pin_sync & dig_mask;

  // Byte strobes expand into a bit mask; only the low N bits matter
  genvar b;
  generate
    for (b = 0; b < `GPM_STRB_W; b = b + 1) begin : g_strb
      assign wmask_full[b*`GPM_BYTE_W +: `GPM_BYTE_W] =
        {`GPM_BYTE_W{PSTRB[b]}};
    end
  endgenerate

  assign wmask = wmask_full[N-1:0];

  // Write data bits above N have no register behind them
  assign wdata = PWDATA[N-1:0];

  // Address decode on the full word offset
  assign hit_dir = (PADDR == `GPM_OFF_DIR);
  assign hit_val = (PADDR == `GPM_OFF_VAL);
  assign hit_lat = (PADDR == `GPM_OFF_LAT);
  assign hit_acfg = (PADDR == `GPM_OFF_ACFG);

  // One wait state: the first access cycle prepares, the second completes
  assign acc_start = PSEL & PENABLE & ~PREADY;
  assign acc_done = PSEL & PENABLE & PREADY;
  assign wr_go = acc_done & PWRITE & ~PSLVERR;

  // Decode error: unmapped offset, or a write to the read-only owner word
  always @* begin
    dec_err = 1'b0;
    case (PADDR)
      `GPM_OFF_DIR,
      `GPM_OFF_VAL,
      `GPM_OFF_LAT,
      `GPM_OFF_ACFG: begin
        dec_err = 1'b0;
      end
      `GPM_OFF_OWN: begin
        dec_err = PWRITE;
      end
      default: begin
        dec_err = 1'b1;
      end
    endcase
  end

  // Per-pin ownership: scan lowest priority first so index 0 wins last
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1) begin : g_pin
      reg own_c;
      reg o_c;
      reg oe_c;
      integer p;
      always @* begin
        own_c = 1'b0;
        o_c = 1'b0;
        oe_c = 1'b0;
        for (p = NP - 1; p >= 0; p = p - 1) begin
          // Input-only functions are ignored here and never take the driver
          if (PER_EN[p*N+i] && PER_TAKES_PIN[p]) begin
            own_c = 1'b1;
            o_c = PER_OUT[p*N+i];
            oe_c = PER_OE[p*N+i];
          end
        end
      end
      assign owned[i] = own_c;
      assign per_o[i] = o_c;
      assign per_oe[i] = oe_c;
    end
  endgenerate

  // Write strobes; a refused access never reaches them
  assign wr_dir = wr_go & hit_dir;
  assign wr_lat = wr_go & (hit_val | hit_lat);
  assign wr_acfg = wr_go & hit_acfg;

  // Byte-lane merge: lanes with a low strobe keep their old bits
  assign dir_merge = (wdata & wmask) | (dir_reg & ~wmask);
  assign lat_merge = (wdata & wmask) | (lat_reg & ~wmask);
  assign acfg_merge = (wdata & wmask) | (acfg_reg & ~wmask);

  // Register write path; unimplemented bits are held at zero
  always @* begin
    dir_next = dir_reg;
    lat_next = lat_reg;
    acfg_next = acfg_reg;
    if (wr_dir) begin
      dir_next = dir_merge & IMPL_MASK;
    end
    // A pin value write goes into the latch only; software doing a
    // read-modify-write here copies sampled input levels into the latch
    if (wr_lat) begin
      lat_next = lat_merge & IMPL_MASK;
    end
    // Only converter-shared pins have a configuration bit
    if (wr_acfg) begin
      acfg_next = acfg_merge & ANALOG_MASK;
    end
  end

  // Pin driver selection, registered so pins never see decode glitches
  always @* begin
    pin_o_next = {N{`GPM_BIT_ZERO}};
    pin_oe_next = {N{`GPM_BIT_ZERO}};
    begin : pin_sel
      integer k;
      for (k = 0; k < N; k = k + 1) begin
        if (!dig_mask[k]) begin
          // Disabled or analog pins are never driven
          pin_o_next[k] = `GPM_BIT_ZERO;
          pin_oe_next[k] = `GPM_BIT_ZERO;
        end else if (owned[k]) begin
          // Peripheral data and enable replace the port's own
          pin_o_next[k] = per_o[k];
          pin_oe_next[k] = per_oe[k];
        end else begin
          pin_o_next[k] = lat_reg[k];
          pin_oe_next[k] = (dir_reg[k] == `GPM_DIR_OUTPUT);
        end
      end
    end
  end

  // Read data multiplexer; bits above N always read zero
  always @* begin
    rdata_next = {`GPM_DATA_W{1'b0}};
    case (PADDR)
      `GPM_OFF_DIR: begin
        rdata_next[N-1:0] = dir_reg & IMPL_MASK;
      end
      `GPM_OFF_VAL: begin
        rdata_next[N-1:0] = pin_read;
      end
      `GPM_OFF_LAT: begin
        rdata_next[N-1:0] = lat_reg & IMPL_MASK;
      end
      `GPM_OFF_ACFG: begin
        rdata_next[N-1:0] = acfg_reg;
      end
      `GPM_OFF_OWN: begin
        rdata_next[N-1:0] = own_reg;
      end
      default: begin
        rdata_next = {`GPM_DATA_W{1'b0}};
      end
    endcase
  end

  // Direction: every implemented pin comes out of reset as an input
  always @(posedge CLK) begin
    if (SRST) begin
      dir_reg <= IMPL_MASK & {N{`GPM_DIR_INPUT}};
    end else begin
      dir_reg <= dir_next;
    end
  end

  // Output latch; cleared so a pin turned output starts low
  always @(posedge CLK) begin
    if (SRST) begin
      lat_reg <= {N{`GPM_LAT_RST}};
    end else begin
      lat_reg <= lat_next;
    end
  end

  // Analog configuration; converter pins start analog, never driven
  always @(posedge CLK) begin
    if (SRST) begin
      acfg_reg <= {N{`GPM_ACFG_RST}};
    end else begin
      acfg_reg <= acfg_next;
    end
  end

  // Pin drive, peripheral input copy and ownership status
  always @(posedge CLK) begin
    if (SRST) begin
      PIN_O <= {N{`GPM_BIT_ZERO}};
      PIN_OE <= {N{`GPM_BIT_ZERO}};
      PER_IN <= {N{`GPM_BIT_ZERO}};
      own_reg <= {N{`GPM_BIT_ZERO}};
    end else begin
      PIN_O <= pin_o_next;
      PIN_OE <= pin_oe_next;
      // Peripherals hear the pin itself, so with the port as output the
      // latch reaches an input-only function through the pad
      PER_IN <= pin_read;
      own_reg <= owned & dig_mask;
    end
  end

  // APB handshake: ready one cycle into the access phase, then drop
  always @(posedge CLK) begin
    if (SRST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end else if (acc_start) begin
      PREADY <= 1'b1;
      PSLVERR <= dec_err;
    end else begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
    end
  end

  // Read data is captured with ready and held until the next answer;
  // writes and refused reads return zero so stale data never leaks out
  always @(posedge CLK) begin
    if (SRST) begin
      PRDATA <= {`GPM_DATA_W{1'b0}};
    end else if (acc_start) begin
      if (!PWRITE && !dec_err) begin
        PRDATA <= rdata_next;
      end else begin
        PRDATA <= {`GPM_DATA_W{1'b0}};
      end
    end
  end

endmodule
`default_nettype wire

// File: testbench/gpm_port_chk.sv
// Port-side assertions for the GPIO port block
`timescale 1ns/100ps
`default_nettype none
module gpm_port_chk #(
  parameter N = 16,
  parameter NP = 2
) (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [N-1:0] PIN_I,
  input wire logic [N-1:0] PIN_O,
  input wire logic [N-1:0] PIN_OE,
  input wire logic [NP*N-1:0] PER_EN,
  input wire logic [NP*N-1:0] PER_OUT,
  input wire logic [NP*N-1:0] PER_OE,
  input wire logic [N-1:0] PER_IN
);
  default clocking @(posedge CLK); endclocking
  default disable iff (SRST);
  // One wait state, then a single-cycle answer
  a_wait_state: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("no answer after one wait state");
  a_ready_pulse: assert property (PREADY |=> !PREADY)
    else $error("ready held too long");
  a_err_map: assert property (PREADY && PADDR > 12'h010 |-> PSLVERR)
    else $error("unmapped offset not refused");
  a_upper_zero: assert property (
    PREADY && !PWRITE |-> PRDATA[31:N] == '0)
    else $error("unused read bits not zero");
  // Register reads and peripheral inputs share one synchronised sample
  a_pin_read: assert property (
    PREADY && !PWRITE && !PSLVERR && PADDR == 12'h004
    |-> PRDATA[N-1:0] == PER_IN)
    else $error("pin read differs from sampled level");
  // Top pin is converter-shared in the bench, so it is shifted out
  a_sync_delay: assert property (
    !$past(SRST) && !$past(SRST, 2) && !$past(SRST, 3)
    |-> ((PER_IN ^ $past(PIN_I, 3)) << 1) == '0)
    else $error("peripheral input not three cycles behind pin");
  a_reset_in: assert property ($past(SRST) |=> PIN_OE == '0)
    else $error("pin driven after reset");
  a_per_owns: assert property (
    PER_EN[0] |=> PIN_O[0] == $past(PER_OUT[0])
    && PIN_OE[0] == $past(PER_OE[0]))
    else $error("enabled peripheral does not own pin");
endmodule
bind gpm_port gpm_port_chk #(.N(N), .NP(NP)) gpm_port_chk_inst (
  .CLK(CLK), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .PIN_I(PIN_I), .PIN_O(PIN_O), .PIN_OE(PIN_OE), .PER_EN(PER_EN),
  .PER_OUT(PER_OUT), .PER_OE(PER_OE), .PER_IN(PER_IN));
`default_nettype wire

// File: testbench/gpm_pads.sv
// Board model: level seen at each pad
`timescale 1ns/100ps
`default_nettype none
module gpm_pads #(
  parameter N = 16
) (
  input wire logic [N-1:0] drv,
  input wire logic [N-1:0] drv_en,
  input wire logic [N-1:0] ext,
  output logic [N-1:0] level
);
  // Driven pads follow the port, released ones the external device
  assign level = (drv & drv_en) | (ext & ~drv_en);
endmodule
`default_nettype wire

// File: testbench/gpm_port_test.sv
// Directed APB and pin tests for the GPIO port block
`timescale 1ns/100ps
`default_nettype none
module gpm_port_test;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] ext = 16'h0;
  logic [31:0] per_en = 32'h0;
  logic [31:0] per_out = 32'h0;
  logic [31:0] per_oe = 32'h0;
  logic [31:0] rdata;
  logic rerr;
  integer n_fail = 0;
  integer checked = 0;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire [15:0] pin_i;
  wire [15:0] pin_o;
  wire [15:0] pin_oe;
  wire [15:0] per_in;
  // Pin 15 is converter-shared so its digital switch gets exercised
  gpm_port #(.ANALOG_MASK(16'h8000)) gpm_port_inst (
    .CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PSTRB(4'hf), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .PIN_I(pin_i), .PIN_O(pin_o),
    .PIN_OE(pin_oe), .PER_EN(per_en), .PER_OUT(per_out), .PER_OE(per_oe),
    .PER_IN(per_in));
  gpm_pads gpm_pads_inst (.drv(pin_o), .drv_en(pin_oe), .ext(ext),
    .level(pin_i));
  initial forever #5 clk = ~clk;
  // Request held until ready is sampled high, then released
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d);
    integer k;
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      k = 0;
      do begin
        @(posedge clk);
        k = k + 1;
      end while (pready !== 1'b1 && k < 50);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
      if (k >= 50) n_fail = n_fail + 1;
    end
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    begin
      xfer(1'b0, a, 32'h0);
      check(rdata, exp);
    end
  endtask
  task automatic conclude;
    begin
      $display("checked=%0d n_fail=%0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
    end
  endtask
  // Whole run is about 120 cycles
  initial begin
    #100000;
    n_fail = n_fail + 1;
    conclude;
  end
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    ext <= 16'hc3a5;
    repeat (3) @(posedge clk);
    check({16'h0, pin_oe}, 32'h0);
    rd(12'h000, 32'h0000ffff);
    rd(12'h004, 32'h000043a5);
    xfer(1'b1, 12'h00c, 32'hffffffff);
    rd(12'h00c, 32'h00008000);
    rd(12'h004, 32'h0000c3a5);
    xfer(1'b1, 12'h008, 32'h12345678);
    rd(12'h008, 32'h00005678);
    rd(12'h004, 32'h0000c3a5);
    xfer(1'b1, 12'h004, 32'h0000abcd);
    rd(12'h008, 32'h0000abcd);
    check({16'h0, pin_oe}, 32'h0);
    $display("test registers ended");
    xfer(1'b1, 12'h000, 32'h000000ff);
    repeat (3) @(posedge clk);
    rd(12'h004, 32'h0000aba5);
    xfer(1'b1, 12'h004, rdata);
    xfer(1'b1, 12'h000, 32'hffff0000);
    rd(12'h000, 32'h0);
    check({pin_oe, pin_o}, 32'hffffaba5);
    $display("test direction ended");
    per_oe <= 32'h00010001;
    per_out <= 32'h00010000;
    per_en <= 32'h00010001;
    repeat (2) @(posedge clk);
    check({16'h0, pin_o}, 32'h0000aba4);
    xfer(1'b1, 12'h008, 32'h0000ffff);
    repeat (3) @(posedge clk);
    check({16'h0, pin_o}, 32'h0000fffe);
    rd(12'h010, 32'h00000001);
    rd(12'h004, 32'h0000fffe);
    per_en <= 32'h00010000;
    repeat (5) @(posedge clk);
    check({pin_o, per_in}, 32'hffffffff);
    $display("test peripherals ended");
    xfer(1'b0, 12'h014, 32'h0);
    check({31'h0, rerr}, 32'h1);
    xfer(1'b1, 12'h010, 32'h0);
    check({31'h0, rerr}, 32'h1);
    rd(12'h010, 32'h0);
    $display("test errors ended");
    conclude;
  end
endmodule
`default_nettype wire
